/* File: design/opmc_top.sv */
`timescale 1ns/1ns
module opmc_top #(
  parameter int FIFO_DEPTH = 8
)
(
  input  logic               mclk_i,
  input  logic               rst_n_i,
  input  logic               reg_wr_i,
  input  logic               reg_rd_i,
  input  opmc_pkg::opmc_addr_t reg_addr_i,
  input  opmc_pkg::opmc_word_t reg_wdata_i,
  output opmc_pkg::opmc_word_t reg_rdata_o,
  input  logic               seq_clk_i,
  input  logic               measure_start_i,
  input  logic               res_valid_i,
  output logic               res_ready_o,
  input  opmc_pkg::opmc_word_t res_x_i,
  input  opmc_pkg::opmc_word_t res_y_i,
  input  opmc_pkg::opmc_word_t res_i_i,
  input  logic               second_on_interrupt_i,
  output logic               fifo_rd_valid_o,
  input  logic               fifo_rd_ready_i,
  output opmc_pkg::opmc_word_t fifo_rd_data_o,
  output logic               record_dropped_o,
  output logic               standby_o,
  output logic               prox_mode_o,
  output logic               sample_mode_o,
  output logic               gesture_mode_o,
  output logic               idle_o,
  output logic               bandgap_core_on_o,
  output logic               blocks_on_o,
  output logic               frontend_active_o,
  output logic [7:0]         ref_startup_o,
  output opmc_pkg::opmc_nib_t  fast_osc_warmup_o,
  output opmc_pkg::opmc_nib_t  digital_time_o,
  output opmc_pkg::opmc_word_t sampling_interval_o
);
  import opmc_pkg::*;

  localparam int FW = $clog2(FIFO_DEPTH+1);

  // the longest record must fit into an empty fifo
  if (FIFO_DEPTH < 4)
  begin : g_bad_fifo
    $error("opmc_top fifo depth must hold one whole record");
  end

  opmc_word_t power_q;
  opmc_word_t frontend_q;
  opmc_word_t interval_q;
  opmc_word_t oper_q;
  opmc_nib_t  sel;
  opmc_nib_t  fmt;
  logic       guard;
  logic       marker;
  logic       promote_en;
  opmc_wr_e   wr_state_q;
  opmc_word_t rec_q [3];
  logic [1:0] len_q;
  logic [1:0] idx_q;
  logic [1:0] rec_len;
  logic       accept;
  logic       fits;
  logic       wr_valid;
  logic       wr_ready;
  logic       wr_fire;
  opmc_word_t wr_data;
  logic [FW-1:0] fifo_free;
  logic       pend_q;
  logic       promote_now;
  logic       seq_s;
  logic       seq_prev_q;
  logic       seq_rise;
  opmc_nib_t  run_cnt_q;

  // register fields
  assign sel        = oper_q[OPMC_SEL_LSB +: 4];
  assign fmt        = oper_q[OPMC_FMT_LSB +: 4];
  assign guard      = oper_q[OPMC_GUARD_BIT];
  assign marker     = oper_q[OPMC_MARK_BIT];
  assign promote_en = oper_q[OPMC_PROMOTE_BIT];

  assign ref_startup_o       = power_q[OPMC_REF_LSB +: 8];
  assign fast_osc_warmup_o   = power_q[OPMC_WARMUP_LSB +: 4];
  assign digital_time_o      = power_q[OPMC_DIGITAL_LSB +: 4];
  assign sampling_interval_o = interval_q;

  // timing registers; reserved bits are kept at zero
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      power_q    <= OPMC_RST_POWER;
      frontend_q <= OPMC_RST_FRONTEND;
      interval_q <= OPMC_RST_INTERVAL;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == OPMC_ADDR_POWER)
        power_q <= reg_wdata_i & OPMC_MASK_POWER;
      if (reg_addr_i == OPMC_ADDR_FRONTEND)
        frontend_q <= reg_wdata_i & OPMC_MASK_FRONTEND;
      if (reg_addr_i == OPMC_ADDR_INTERVAL)
        interval_q <= reg_wdata_i & OPMC_MASK_INTERVAL;
    end
  end

  // operation register; a promotion wins over the selector field of a host write
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      oper_q <= OPMC_RST_OPER;
    else
    begin
      if (reg_wr_i && reg_addr_i == OPMC_ADDR_OPER)
        oper_q <= reg_wdata_i & OPMC_MASK_OPER;
      if (promote_now)
        oper_q[OPMC_SEL_LSB +: 4] <= OPMC_SEL_SAMPLE;
    end
  end

  // read data, unmapped addresses read zero
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= '0;
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        OPMC_ADDR_POWER:    reg_rdata_o <= power_q;
        OPMC_ADDR_FRONTEND: reg_rdata_o <= frontend_q;
        OPMC_ADDR_INTERVAL: reg_rdata_o <= interval_q;
        OPMC_ADDR_OPER:     reg_rdata_o <= oper_q;
        default:            reg_rdata_o <= '0;
      endcase
    end
  end

  // mode decode into power and mode outputs
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      standby_o         <= 1'b1;
      prox_mode_o       <= 1'b0;
      sample_mode_o     <= 1'b0;
      gesture_mode_o    <= 1'b0;
      idle_o            <= 1'b0;
      bandgap_core_on_o <= 1'b0;
      blocks_on_o       <= 1'b0;
    end
    else
    begin
      standby_o         <= (sel == OPMC_SEL_STANDBY);
      prox_mode_o       <= (sel == OPMC_SEL_PROX);
      sample_mode_o     <= (sel == OPMC_SEL_SAMPLE);
      gesture_mode_o    <= (sel == OPMC_SEL_GEST);
      idle_o            <= (sel == OPMC_SEL_IDLE);
      bandgap_core_on_o <= (sel != OPMC_SEL_STANDBY);
      blocks_on_o       <= (sel == OPMC_SEL_PROX) || (sel == OPMC_SEL_SAMPLE)
                           || (sel == OPMC_SEL_GEST);
    end
  end

  // record length from selector and format
  always_comb
  begin
    rec_len = OPMC_LEN_NONE;
    unique case (sel)
      OPMC_SEL_PROX:
      begin
        if (fmt == OPMC_FMT_INTENSITY)
          rec_len = OPMC_LEN_INTENSITY;
        else if (fmt == OPMC_FMT_POSITION)
          rec_len = OPMC_LEN_POSITION;
      end
      OPMC_SEL_SAMPLE, OPMC_SEL_GEST:
        rec_len = OPMC_LEN_SAMPLE;
      default:
        rec_len = OPMC_LEN_NONE;
    endcase
  end

  // record acceptance and space check
  assign res_ready_o = (wr_state_q == OPMC_WR_IDLE);
  assign accept      = res_valid_i && res_ready_o;
  assign fits        = !guard || (fifo_free >= FW'(rec_len));

  // record writer
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      wr_state_q       <= OPMC_WR_IDLE;
      len_q            <= '0;
      idx_q            <= '0;
      record_dropped_o <= 1'b0;
      rec_q[0]         <= '0;
      rec_q[1]         <= '0;
      rec_q[2]         <= '0;
    end
    else
    begin
      record_dropped_o <= 1'b0;
      unique case (wr_state_q)
        OPMC_WR_IDLE:
        begin
          if (accept && rec_len != OPMC_LEN_NONE)
          begin
            if (fits)
            begin
              wr_state_q <= OPMC_WR_EMIT;
              len_q      <= rec_len;
              idx_q      <= '0;
              rec_q[0]   <= (rec_len == OPMC_LEN_INTENSITY) ? res_i_i : res_x_i;
              rec_q[1]   <= res_y_i;
              rec_q[2]   <= res_i_i;
            end
            else
              record_dropped_o <= 1'b1;
          end
        end
        OPMC_WR_EMIT:
        begin
          if (wr_fire)
          begin
            idx_q <= idx_q + 2'h1;
            if (idx_q == len_q - 2'h1)
              wr_state_q <= OPMC_WR_IDLE;
          end
        end
      endcase
    end
  end

  // fifo word with optional record start marker
  assign wr_valid = (wr_state_q == OPMC_WR_EMIT);
  assign wr_fire  = wr_valid && wr_ready;
  always_comb
  begin
    wr_data = rec_q[idx_q];
    if (marker)
      wr_data[0] = (idx_q == 2'h0);
  end

  opmc_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (wr_valid),
    .in_ready_o  (wr_ready),
    .in_data_i   (wr_data),
    .out_valid_o (fifo_rd_valid_o),
    .out_ready_i (fifo_rd_ready_i),
    .out_data_o  (fifo_rd_data_o),
    .free_o      (fifo_free)
  );

  // pending promotion; a new interrupt wins over the clear
  assign promote_now = pend_q && (wr_state_q == OPMC_WR_IDLE);
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      pend_q <= 1'b0;
    else if (sel == OPMC_SEL_PROX && promote_en && second_on_interrupt_i)
      pend_q <= 1'b1;
    else if (promote_now || sel != OPMC_SEL_PROX || !promote_en)
      pend_q <= 1'b0;
  end

  // sequencing clock edge detect
  opmc_sync u_seq_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .async_i (seq_clk_i),
    .sync_o  (seq_s)
  );
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      seq_prev_q <= 1'b0;
    else
      seq_prev_q <= seq_s;
  end
  assign seq_rise = seq_s && !seq_prev_q;

  // front end run counter in sequencing clock periods
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      run_cnt_q <= '0;
    else if (measure_start_i && blocks_on_o)
      run_cnt_q <= frontend_q[OPMC_RUN_LSB +: 4];
    else if (seq_rise && run_cnt_q != 4'h0)
      run_cnt_q <= run_cnt_q - 4'h1;
  end
  assign frontend_active_o = (run_cnt_q != 4'h0);

  // checks
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_accept_len(logic [1:0] n);
    accept && rec_len == n && fits;
  endsequence

  sequence s_first_word;
    wr_valid && idx_q == 2'h0;
  endsequence

  a_sel_decode: assert property (
    $past(sel) == OPMC_SEL_SAMPLE |-> sample_mode_o && !standby_o && !prox_mode_o)
    else $error("sample selector not decoded");

  a_idle_bias: assert property (
    idle_o |-> bandgap_core_on_o && !blocks_on_o && !standby_o)
    else $error("idle power state wrong");

  a_prox_one_word: assert property (
    s_accept_len(OPMC_LEN_INTENSITY) |=> s_first_word ##0 wr_data[15:1] == $past(res_i_i[15:1]))
    else $error("intensity record not started");

  a_prox_three_words: assert property (
    wr_fire && len_q == OPMC_LEN_POSITION && idx_q == 2'h2 |=> wr_state_q == OPMC_WR_IDLE)
    else $error("position record not three words");

  a_store_none: assert property (
    accept && sel == OPMC_SEL_PROX && rec_len == OPMC_LEN_NONE |=> !wr_valid [*2])
    else $error("stored record for empty format");

  a_guard_drop: assert property (
    accept && rec_len != OPMC_LEN_NONE && !fits |=> record_dropped_o && !wr_valid)
    else $error("record not dropped when guard set");

  a_start_marker: assert property (
    wr_valid && marker |-> wr_data[0] == (idx_q == 2'h0))
    else $error("record start marker wrong");

  a_auto_promote: assert property (
    sel == OPMC_SEL_PROX && promote_en && second_on_interrupt_i && wr_state_q == OPMC_WR_IDLE
    |=> ##1 sel == OPMC_SEL_SAMPLE)
    else $error("proximity not promoted");

  a_frontend_run: assert property (
    measure_start_i && blocks_on_o && frontend_q[3:0] != 4'h0
    |=> frontend_active_o && run_cnt_q == $past(frontend_q[3:0]))
    else $error("front end not held active");

endmodule

/* File: design/opmc_pkg.sv */
package opmc_pkg;

  // register port types
  typedef logic [7:0]  opmc_addr_t;
  typedef logic [15:0] opmc_word_t;
  typedef logic [3:0]  opmc_nib_t;

  // register addresses
  localparam opmc_addr_t OPMC_ADDR_POWER     = 8'h42;
  localparam opmc_addr_t OPMC_ADDR_FRONTEND  = 8'h43;
  localparam opmc_addr_t OPMC_ADDR_INTERVAL  = 8'h44;
  localparam opmc_addr_t OPMC_ADDR_OPER      = 8'h45;

  // values after reset
  localparam opmc_word_t OPMC_RST_POWER      = 16'h4000;
  localparam opmc_word_t OPMC_RST_FRONTEND   = 16'h0000;
  localparam opmc_word_t OPMC_RST_INTERVAL   = 16'h0000;
  localparam opmc_word_t OPMC_RST_OPER       = 16'h0000;

  // implemented bits, reserved bits read as zero
  localparam opmc_word_t OPMC_MASK_POWER     = 16'hFFFF;
  localparam opmc_word_t OPMC_MASK_FRONTEND  = 16'h000F;
  localparam opmc_word_t OPMC_MASK_INTERVAL  = 16'hFFFF;
  localparam opmc_word_t OPMC_MASK_OPER      = 16'h07FF;

  // field positions
  localparam int OPMC_REF_LSB      = 0;
  localparam int OPMC_WARMUP_LSB   = 8;
  localparam int OPMC_DIGITAL_LSB  = 12;
  localparam int OPMC_RUN_LSB      = 0;
  localparam int OPMC_SEL_LSB      = 0;
  localparam int OPMC_FMT_LSB      = 4;
  localparam int OPMC_GUARD_BIT    = 8;
  localparam int OPMC_MARK_BIT     = 9;
  localparam int OPMC_PROMOTE_BIT  = 10;

  // operation selector codes
  localparam opmc_nib_t OPMC_SEL_STANDBY = 4'h0;
  localparam opmc_nib_t OPMC_SEL_PROX    = 4'h1;
  localparam opmc_nib_t OPMC_SEL_GEST    = 4'h2;
  localparam opmc_nib_t OPMC_SEL_SAMPLE  = 4'h3;
  localparam opmc_nib_t OPMC_SEL_IDLE    = 4'hF;

  // record format codes and record lengths in 16-bit words
  localparam opmc_nib_t  OPMC_FMT_INTENSITY = 4'h1;
  localparam opmc_nib_t  OPMC_FMT_POSITION  = 4'h3;
  localparam logic [1:0] OPMC_LEN_NONE      = 2'h0;
  localparam logic [1:0] OPMC_LEN_INTENSITY = 2'h1;
  localparam logic [1:0] OPMC_LEN_SAMPLE    = 2'h2;
  localparam logic [1:0] OPMC_LEN_POSITION  = 2'h3;

  // record writer states
  typedef enum logic [1:0]
  {
    OPMC_WR_IDLE = 2'b01,
    OPMC_WR_EMIT = 2'b10
  } opmc_wr_e;

endpackage

/* File: design/opmc_sync.sv */
`timescale 1ns/1ns
module opmc_sync
(
  input  logic mclk_i,
  input  logic rst_n_i,
  input  logic async_i,
  output logic sync_o
);

  logic meta_q;

  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

/* File: design/opmc_fifo.sv */
`timescale 1ns/1ns
module opmc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
)
(
  input  logic                       mclk_i,
  input  logic                       rst_n_i,
  input  logic                       in_valid_i,
  output logic                       in_ready_o,
  input  logic [WIDTH-1:0]           in_data_i,
  output logic                       out_valid_o,
  input  logic                       out_ready_i,
  output logic [WIDTH-1:0]           out_data_o,
  output logic [$clog2(DEPTH+1)-1:0] free_o
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  // depth must be a power of two of at least two
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("opmc_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wptr_q;
  logic [AW-1:0]    rptr_q;
  logic [CW-1:0]    count_q;
  logic             push;
  logic             load_out;
  logic [CW-1:0]    held;

  // handshakes; held words include the output register, so depth is the true capacity
  assign held        = count_q + CW'(out_valid_o);
  assign in_ready_o  = (held != CW'(DEPTH));
  assign push        = in_valid_i && in_ready_o;
  assign load_out    = (count_q != '0) && (!out_valid_o || out_ready_i);
  assign free_o      = CW'(DEPTH) - held;

  // storage array
  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem_q[wptr_q] <= in_data_i;
  end

  // pointers and fill level
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      wptr_q  <= '0;
      rptr_q  <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wptr_q <= wptr_q + AW'(1);
      if (load_out)
        rptr_q <= rptr_q + AW'(1);
      count_q <= count_q + CW'(push) - CW'(load_out);
    end
  end

  // registered read data
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end
    else if (load_out)
    begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem_q[rptr_q];
    end
    else if (out_ready_i)
      out_valid_o <= 1'b0;
  end

endmodule

/* File: verif/opmc_far.sv */
`timescale 1ns/1ns
module opmc_far
(
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  input  wire logic             send_i,
  input  wire logic             stall_i,
  input  wire logic [47:0]      rec_i,
  input  wire logic             res_ready_i,
  output logic                  res_valid_o,
  output opmc_pkg::opmc_word_t  res_x_o,
  output opmc_pkg::opmc_word_t  res_y_o,
  output opmc_pkg::opmc_word_t  res_i_o,
  output logic                  fifo_rd_ready_o
);
  import opmc_pkg::*;

  // result source: hold until taken, then show inverted stale data
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      res_valid_o <= 1'b0;
      {res_x_o, res_y_o, res_i_o} <= 48'h0000_0000_0000;
    end
    else if (res_valid_o && res_ready_i)
    begin
      res_valid_o <= 1'b0;
      {res_x_o, res_y_o, res_i_o} <= ~{res_x_o, res_y_o, res_i_o};
    end
    else if (send_i)
    begin
      res_valid_o <= 1'b1;
      {res_x_o, res_y_o, res_i_o} <= rec_i;
    end
  end

  // fifo consumer, stalls on request
  assign fifo_rd_ready_o = !stall_i;
endmodule

/* File: verif/tb_operation_mode_control.sv */
`timescale 1ns/1ns
module tb_operation_mode_control;
  import opmc_pkg::*;

  logic mclk_i, rst_n_i, reg_wr, reg_rd, seq_clk, meas, so_int, send, stall;
  logic res_valid, res_ready, rd_valid, rd_ready, dropped;
  logic standby, prox, samp, gest, idle, bg_on, blk_on, fe_act;
  opmc_addr_t addr;
  opmc_word_t wdata, rdata, rx, ry, ri, rd_data, interval;
  opmc_nib_t  warm, dig;
  logic [7:0] ref_t;
  logic [47:0] rec;
  opmc_word_t got[$];
  int fail_count, compares, drops, k;
  // addr, write data, read back
  logic [39:0] reg_rows [5] = '{40'h42_A5C3_A5C3, 40'h43_FFFF_000F, 40'h44_1234_1234,
                                40'h45_FFFF_07FF, 40'h46_FFFF_0000};
  // selector, standby prox sample gesture idle bias blocks
  logic [10:0] mode_rows [5] = '{{4'h0, 7'b1000000}, {4'h1, 7'b0100011},
                                 {4'h2, 7'b0001011}, {4'h3, 7'b0010011},
                                 {4'hF, 7'b0000110}};
  // control word, word count, expected words
  logic [65:0] rec_rows [10] = '{{16'h0011, 2'd1, 48'h3C3C_0000_0000},
    {16'h0211, 2'd1, 48'h3C3D_0000_0000}, {16'h0031, 2'd3, 48'hA5A4_5A5B_3C3C},
    {16'h0231, 2'd3, 48'hA5A5_5A5A_3C3C}, {16'h0001, 2'd0, 48'h0},
    {16'h0051, 2'd0, 48'h0}, {16'h0003, 2'd2, 48'hA5A4_5A5B_0000},
    {16'h0002, 2'd2, 48'hA5A4_5A5B_0000}, {16'h0000, 2'd0, 48'h0},
    {16'h000F, 2'd0, 48'h0}};

  opmc_top #(.FIFO_DEPTH(8)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .seq_clk_i(seq_clk), .measure_start_i(meas), .res_valid_i(res_valid),
    .res_ready_o(res_ready), .res_x_i(rx), .res_y_i(ry), .res_i_i(ri),
    .second_on_interrupt_i(so_int), .fifo_rd_valid_o(rd_valid), .fifo_rd_ready_i(rd_ready),
    .fifo_rd_data_o(rd_data), .record_dropped_o(dropped), .standby_o(standby),
    .prox_mode_o(prox), .sample_mode_o(samp), .gesture_mode_o(gest), .idle_o(idle),
    .bandgap_core_on_o(bg_on), .blocks_on_o(blk_on), .frontend_active_o(fe_act),
    .ref_startup_o(ref_t), .fast_osc_warmup_o(warm), .digital_time_o(dig),
    .sampling_interval_o(interval));

  opmc_far far (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .send_i(send), .stall_i(stall),
    .rec_i(rec), .res_ready_i(res_ready), .res_valid_o(res_valid), .res_x_o(rx),
    .res_y_o(ry), .res_i_o(ri), .fifo_rd_ready_o(rd_ready));

  // clocks: system 20 ns, sequencing 160 ns at unrelated phase
  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  initial
  begin
    seq_clk = 1'b0;
    #37;
    forever #80 seq_clk = ~seq_clk;
  end

  // collect words leaving the fifo and count drop pulses
  always @(posedge mclk_i)
  begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
      got.push_back(rd_data);
    if (dropped === 1'b1)
      drops++;
  end

  task chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task wr(input opmc_addr_t a, input opmc_word_t d);
    @(negedge mclk_i);
    reg_wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge mclk_i);
    reg_wr = 1'b0;
  endtask

  task rd(input opmc_addr_t a, input opmc_word_t e);
    @(negedge mclk_i);
    reg_rd = 1'b1;
    addr = a;
    @(negedge mclk_i);
    reg_rd = 1'b0;
    chk(rdata, e);
  endtask

  // offer one result; optionally wait until the writer is idle again
  task send_rec(input logic [47:0] r, input logic w);
    @(negedge mclk_i);
    rec = r;
    send = 1'b1;
    @(negedge mclk_i);
    send = 1'b0;
    for (int n = 0; n < 40 && w && !(res_ready === 1'b1 && res_valid === 1'b0); n++)
      @(negedge mclk_i);
  endtask

  // compare collected words against n expected words
  task chk_got(input int n, input logic [47:0] e);
    repeat (20) @(negedge mclk_i);
    chk(16'(got.size()), 16'(n));
    for (int j = 0; j < n && j < got.size(); j++)
      chk(got[j], e[47-16*(j%3) -: 16]);
    got.delete();
  endtask

  task do_reset;
    rst_n_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_n_i = 1'b1;
  endtask

  task test_done;
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #400000;
    fail_count++;
    test_done;
  end

  initial
  begin
    {reg_wr, reg_rd, meas, so_int, send, stall} = 6'h00;
    addr = 8'h00;
    wdata = 16'h0000;
    rec = 48'h0;
    do_reset;
    rd(OPMC_ADDR_POWER, OPMC_RST_POWER);
    rd(OPMC_ADDR_FRONTEND, 16'h0000);
    rd(OPMC_ADDR_INTERVAL, 16'h0000);
    rd(OPMC_ADDR_OPER, 16'h0000);
    chk(16'(dig), 16'h0004);
    chk(16'(standby), 16'h0001);
    for (k = 0; k < 5; k++)
    begin
      wr(reg_rows[k][39:32], reg_rows[k][31:16]);
      rd(reg_rows[k][39:32], reg_rows[k][15:0]);
    end
    chk(interval, 16'h1234);
    chk({dig, warm, ref_t}, 16'hA5C3);
    for (k = 0; k < 5; k++)
    begin
      wr(OPMC_ADDR_OPER, {12'h000, mode_rows[k][10:7]});
      repeat (2) @(negedge mclk_i);
      chk(16'({standby, prox, samp, gest, idle, bg_on, blk_on}), 16'(mode_rows[k][6:0]));
    end
    for (k = 0; k < 10; k++)
    begin
      wr(OPMC_ADDR_OPER, rec_rows[k][65:50]);
      send_rec(48'hA5A4_5A5B_3C3C, 1'b1);
      chk_got(int'(rec_rows[k][49:48]), rec_rows[k][47:0]);
    end
    // guard set: third three-word record cannot fit in eight words
    wr(OPMC_ADDR_OPER, 16'h0131);
    stall = 1'b1;
    repeat (3) send_rec(48'h1110_2220_3330, 1'b1);
    repeat (2) @(negedge mclk_i);
    chk(16'(drops), 16'h0001);
    stall = 1'b0;
    chk_got(6, 48'h1110_2220_3330);
    got.delete();
    // guard clear: fill until the writer stalls, then drain
    wr(OPMC_ADDR_OPER, 16'h0011);
    stall = 1'b1;
    for (k = 0; k < 8; k++)
      send_rec({32'h0, 16'(k * 16)}, 1'b1);
    send_rec({32'h0, 16'h0080}, 1'b0);
    repeat (10) @(negedge mclk_i);
    chk(16'(res_ready), 16'h0000);
    stall = 1'b0;
    repeat (30) @(negedge mclk_i);
    chk(16'(got.size()), 16'h0009);
    for (k = 0; k < 9 && k < got.size(); k++)
      chk(got[k], 16'(k * 16));
    got.delete();
    // auto promote on second-on, and no promotion when disabled
    for (k = 0; k < 2; k++)
    begin
      wr(OPMC_ADDR_OPER, k ? 16'h0011 : 16'h0411);
      @(negedge mclk_i);
      so_int = 1'b1;
      @(negedge mclk_i);
      so_int = 1'b0;
      repeat (5) @(negedge mclk_i);
      chk(16'(samp), k ? 16'h0000 : 16'h0001);
      rd(OPMC_ADDR_OPER, k ? 16'h0011 : 16'h0413);
    end
    // front end run of three sequencing periods
    wr(OPMC_ADDR_FRONTEND, 16'h0003);
    wr(OPMC_ADDR_OPER, 16'h0001);
    repeat (2) @(negedge mclk_i);
    meas = 1'b1;
    @(negedge mclk_i);
    meas = 1'b0;
    repeat (2) @(negedge mclk_i);
    chk(16'(fe_act), 16'h0001);
    repeat (10) @(negedge mclk_i);
    chk(16'(fe_act), 16'h0001);
    repeat (22) @(negedge mclk_i);
    chk(16'(fe_act), 16'h0000);
    // second reset in mid-run
    wr(OPMC_ADDR_INTERVAL, 16'hBEEF);
    do_reset;
    rd(OPMC_ADDR_INTERVAL, 16'h0000);
    chk(16'(standby), 16'h0001);
    chk(16'({res_ready, rd_valid, fe_act, dropped, ref_t}), 16'h0800);
    test_done;
  end
endmodule
